// ---- prc_pkg.sv ----
// Purpose: constants and types for the reset-event interrupt and clock-output register bank
// Assumes: one management clock, registers reached by serial management frames
// Notes: Summary of operation follows below
//
// Summary of operation
// - interrupt output asserts for a reset event only while enable bit 4 is set.
// - enable bit 4 takes its default from a strap pin after every reset.
// - reset interrupt only when strap or config selects power-down after reset.
// - status bit 4 latches on hardware reset and clears when the register is read.
// - host reads status to clear; interrupt output releases once the latch clears.
// - clock config bit 5 selects the 125 MHz recovered clock for the gp pin.
// - clock config bit 4 selects the 125 MHz free-running clock for the gp pin.
// - clock config bit 3 enables the 25 MHz reference output; resets to one.
// - clock config bit 2 selects the recovered heartbeat clock for the gp pin.
// - clock config bit 1 selects the free-running heartbeat clock for the gp pin.
// - clock config bit 0 routes the crystal clock through logic to the gp pin.
// - registers answer clause 45 frames at device address 0x1E.
// - clause 22 registers 0x10 and 0x11 give indirect access to the same registers.

package prc_pkg;

    // ==========================================================
    // register map
    localparam logic [15:0] ADDR_IRQ_ENABLE = 16'hff1d;
    localparam logic [15:0] ADDR_IRQ_STATUS = 16'hff1e;
    localparam logic [15:0] ADDR_CLK_CFG = 16'hff1f;
    localparam logic [15:0] IRQ_ENABLE_RESET = 16'h000e;
    localparam logic [15:0] CLK_CFG_RESET = 16'h0008;
    localparam logic [15:0] ADDR_RESET = 16'h0000;
    localparam logic [15:0] READ_ZERO = 16'h0000;

    // ==========================================================
    // field positions
    localparam int RESET_EVENT_BIT = 4;
    localparam int CLK_CFG_WIDTH = 6;
    localparam int BIT_RECOVERED_FAST = 5;
    localparam int BIT_FREE_FAST = 4;
    localparam int BIT_REF_OUTPUT = 3;
    localparam int BIT_RECOVERED_HEARTBEAT = 2;
    localparam int BIT_FREE_HEARTBEAT = 1;
    localparam int BIT_CRYSTAL = 0;

    // ==========================================================
    // management frame fields
    localparam logic [4:0] SUBSYS_DEVAD = 5'h1e;
    localparam logic [4:0] C22_EXT_ADDR_REG = 5'h10;
    localparam logic [4:0] C22_EXT_DATA_REG = 5'h11;
    localparam logic [1:0] ST_C22 = 2'h1;
    localparam logic [1:0] ST_C45 = 2'h0;
    localparam logic [1:0] OP_C22_WRITE = 2'h1;
    localparam logic [1:0] OP_C22_READ = 2'h2;
    localparam logic [1:0] OP_C45_ADDR = 2'h0;
    localparam logic [1:0] OP_C45_WRITE = 2'h1;
    localparam logic [1:0] OP_C45_READ_INC = 2'h2;
    localparam logic [5:0] PREAMBLE_ONES = 6'h20;
    localparam logic [4:0] HDR_LAST = 5'h0c;
    localparam logic [4:0] DATA_LAST = 5'h0f;

    // ==========================================================
    // startup: strap sync latency before capture
    localparam logic [1:0] STARTUP_LAST = 2'h2;

    typedef enum logic [3:0] {
        FR_IDLE = 4'h1,
        FR_HDR = 4'h2,
        FR_TA = 4'h4,
        FR_DATA = 4'h8
    } prc_frame_state_type;

    typedef enum logic [2:0] {
        GP_NONE = 3'h0,
        GP_RECOVERED_FAST = 3'h1,
        GP_FREE_FAST = 3'h2,
        GP_RECOVERED_HEARTBEAT = 3'h3,
        GP_FREE_HEARTBEAT = 3'h4,
        GP_CRYSTAL = 3'h5
    } prc_gp_source_type;

endpackage

// ---- prc_mdio_frame.sv ----
// Purpose: serial management frame engine, clause 22 and clause 45 framing
// Assumes: mdc_rise and mdio_bit already synchronised and aligned
// Notes: read data sampled at the first turnaround edge
`timescale 1ns/1ps
`default_nettype none

module prc_mdio_frame
    import prc_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic mdc_rise,
    input wire logic mdio_bit,
    input wire logic [4:0] phy_addr,
    input wire logic [15:0] rd_data,
    output logic rd_req,
    output logic wr_req,
    output logic frame_c45,
    output logic [1:0] frame_op,
    output logic [4:0] frame_reg,
    output logic [15:0] wr_data,
    output logic mdio_out,
    output logic mdio_oe
);

    prc_frame_state_type state;
    logic [5:0] ones;
    logic [4:0] cnt;
    logic [13:0] hdr;
    logic [15:0] sh;
    logic mine;
    logic is_read;

    // ==========================================================
    // header decode
    wire [13:0] next_hdr = {hdr[12:0], mdio_bit};
    wire [1:0] hdr_st = next_hdr[13:12];
    wire [1:0] hdr_op = next_hdr[11:10];
    wire [4:0] hdr_phy = next_hdr[9:5];
    wire [4:0] hdr_reg = next_hdr[4:0];
    wire hdr_c45 = (hdr_st == ST_C45);
    wire hdr_c22 = (hdr_st == ST_C22);
    wire hdr_c22_ok = hdr_c22 && (hdr_op == OP_C22_WRITE || hdr_op == OP_C22_READ);
    wire hdr_c45_ok = hdr_c45 && (hdr_reg == SUBSYS_DEVAD);
    wire hdr_mine = (hdr_phy == phy_addr) && (hdr_c22_ok || hdr_c45_ok);
    // clause 45 read and post-read-increment both carry op bit 1
    wire hdr_read = hdr_c22 ? (hdr_op == OP_C22_READ) : hdr_op[1];
    wire preamble_full = (ones == PREAMBLE_ONES);

    assign wr_data = sh;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state <= FR_IDLE;
            ones <= '0;
            cnt <= '0;
            hdr <= '0;
            sh <= '0;
            mine <= 1'b0;
            is_read <= 1'b0;
            rd_req <= 1'b0;
            wr_req <= 1'b0;
            frame_c45 <= 1'b0;
            frame_op <= '0;
            frame_reg <= '0;
            mdio_out <= 1'b0;
            mdio_oe <= 1'b0;
        end else begin
            rd_req <= 1'b0;
            wr_req <= 1'b0;
            if (mdc_rise) begin
                case (state)
                    FR_IDLE: begin
                        if (mdio_bit) begin
                            ones <= preamble_full ? ones : ones + 6'h01;
                        end else begin
                            ones <= '0;
                            if (preamble_full) begin
                                state <= FR_HDR;
                                hdr <= '0;
                                cnt <= '0;
                            end
                        end
                    end
                    FR_HDR: begin
                        hdr <= next_hdr;
                        cnt <= cnt + 5'h01;
                        if (cnt == HDR_LAST) begin
                            state <= FR_TA;
                            cnt <= '0;
                            frame_c45 <= hdr_c45;
                            frame_op <= hdr_op;
                            frame_reg <= hdr_reg;
                            mine <= hdr_mine;
                            is_read <= hdr_read;
                        end
                    end
                    FR_TA: begin
                        if (cnt == '0) begin
                            cnt <= 5'h01;
                            if (mine && is_read) begin
                                mdio_oe <= 1'b1;
                                mdio_out <= 1'b0;
                                rd_req <= 1'b1;
                                sh <= rd_data;
                            end
                        end else begin
                            state <= FR_DATA;
                            cnt <= '0;
                            if (mdio_oe) begin
                                mdio_out <= sh[15];
                                sh <= {sh[14:0], 1'b0};
                            end
                        end
                    end
                    FR_DATA: begin
                        cnt <= cnt + 5'h01;
                        if (is_read) begin
                            mdio_out <= (cnt == DATA_LAST) ? 1'b0 : sh[15];
                            sh <= {sh[14:0], 1'b0};
                            if (cnt == DATA_LAST) begin
                                mdio_oe <= 1'b0;
                            end
                        end else begin
                            sh <= {sh[14:0], mdio_bit};
                        end
                        if (cnt == DATA_LAST) begin
                            state <= FR_IDLE;
                            cnt <= '0;
                            wr_req <= mine && !is_read;
                        end
                    end
                    default: begin
                        state <= FR_IDLE;
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // checks
    a_turnaround_low: assert property (@(posedge mclk) disable iff (!nrst)
        $rose(mdio_oe) |-> !mdio_out && rd_req)
        else $error("turnaround bit not driven low");
    a_release_idle: assert property (@(posedge mclk) disable iff (!nrst)
        $fell(mdio_oe) |-> state == FR_IDLE)
        else $error("data line released outside frame end");

endmodule

`default_nettype wire

// ---- prc_reg_bank.sv ----
// Purpose: reset-event interrupt and clock-output select registers behind management frames
// Assumes: mdc, mdio and straps come from pins; power-down config from same-clock logic
// Notes: clock muxes live outside; this block only drives their selects
`timescale 1ns/1ps
`default_nettype none

module prc_reg_bank
    import prc_pkg::*;
#(
    parameter logic [4:0] PHY_ADDR = 5'h00
)
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic mdc,
    input wire logic mdio_in,
    output logic mdio_out,
    output logic mdio_oe,
    input wire logic powerdown_strap,
    input wire logic crystal_50mhz_strap,
    input wire logic powerdown_after_reset_cfg,
    output logic int_n,
    output prc_gp_source_type gp_clock_source,
    output logic ref_clock_out_enable,
    output logic ref_clock_divide
);

    // ==========================================================
    // pin synchronisers
    logic [3:0] pin_s1;
    logic [3:0] pin_s2;
    logic mdc_prev;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pin_s1 <= 4'h0;
            pin_s2 <= 4'h0;
            mdc_prev <= 1'b0;
        end else begin
            pin_s1 <= {crystal_50mhz_strap, powerdown_strap, mdio_in, mdc};
            pin_s2 <= pin_s1;
            mdc_prev <= pin_s2[0];
        end
    end

    wire mdc_sync = pin_s2[0];
    wire mdio_sync = pin_s2[1];
    wire pd_strap_sync = pin_s2[2];
    wire x50_strap_sync = pin_s2[3];
    wire mdc_rise = mdc_sync && !mdc_prev;

    // ==========================================================
    // startup: strap capture once sync chain has settled
    logic [1:0] start_cnt;
    logic started;
    wire capture = !started && (start_cnt == STARTUP_LAST);

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            start_cnt <= 2'h0;
            started <= 1'b0;
        end else begin
            start_cnt <= started ? start_cnt : start_cnt + 2'h1;
            started <= started || capture;
        end
    end

    // ==========================================================
    // frame engine
    logic rd_req;
    logic wr_req;
    logic frame_c45;
    logic [1:0] frame_op;
    logic [4:0] frame_reg;
    logic [15:0] wr_data;
    logic [15:0] rd_data;

    prc_mdio_frame i_prc_mdio_frame (
        .mclk(mclk),
        .nrst(nrst),
        .mdc_rise(mdc_rise),
        .mdio_bit(mdio_sync),
        .phy_addr(PHY_ADDR),
        .rd_data(rd_data),
        .rd_req(rd_req),
        .wr_req(wr_req),
        .frame_c45(frame_c45),
        .frame_op(frame_op),
        .frame_reg(frame_reg),
        .wr_data(wr_data),
        .mdio_out(mdio_out),
        .mdio_oe(mdio_oe)
    );

    // ==========================================================
    // registers
    logic [15:0] irq_enable;
    logic reset_event_latched;
    logic [CLK_CFG_WIDTH-1:0] clk_cfg;
    logic [15:0] c45_addr;
    logic [15:0] ext_addr;

    // ==========================================================
    // address decode
    wire is_ext_ptr = !frame_c45 && (frame_reg == C22_EXT_ADDR_REG);
    wire is_ext_data = !frame_c45 && (frame_reg == C22_EXT_DATA_REG);
    wire sub_access = frame_c45 || is_ext_data;
    wire [15:0] target = frame_c45 ? c45_addr : ext_addr;

    function automatic logic sub_hit(input logic acc, input logic [15:0] addr,
                                     input logic [15:0] off);
        sub_hit = acc && (addr == off);
    endfunction

    wire hit_enable = sub_hit(sub_access, target, ADDR_IRQ_ENABLE);
    wire hit_status = sub_hit(sub_access, target, ADDR_IRQ_STATUS);
    wire hit_clk = sub_hit(sub_access, target, ADDR_CLK_CFG);

    wire [15:0] status_word = 16'(reset_event_latched) << RESET_EVENT_BIT;
    wire [15:0] clk_word = 16'(clk_cfg);

    // unmapped addresses read as zero and ignore writes
    assign rd_data = is_ext_ptr ? ext_addr :
                     hit_enable ? irq_enable :
                     hit_status ? status_word :
                     hit_clk ? clk_word : READ_ZERO;

    wire reg_write = wr_req && (frame_c45 ? (frame_op == OP_C45_WRITE) : 1'b1);
    wire c45_addr_load = wr_req && frame_c45 && (frame_op == OP_C45_ADDR);
    wire c45_addr_inc = rd_req && frame_c45 && (frame_op == OP_C45_READ_INC);
    wire status_clear = rd_req && hit_status;

    // ==========================================================
    // next values
    wire [15:0] enable_written = (reg_write && hit_enable) ? wr_data : irq_enable;
    logic [15:0] next_irq_enable;
    always_comb begin
        next_irq_enable = enable_written;
        if (capture) begin
            next_irq_enable[RESET_EVENT_BIT] = pd_strap_sync;
        end
    end

    // set beats a clear arriving in the same cycle
    wire next_latched = capture ? 1'b1 : (status_clear ? 1'b0 : reset_event_latched);

    wire [CLK_CFG_WIDTH-1:0] next_clk_cfg = (reg_write && hit_clk) ?
                                           wr_data[CLK_CFG_WIDTH-1:0] : clk_cfg;

    wire [15:0] next_c45_addr = c45_addr_load ? wr_data :
                                c45_addr_inc ? c45_addr + 16'h0001 : c45_addr;
    wire [15:0] next_ext_addr = (reg_write && is_ext_ptr) ? wr_data : ext_addr;

    wire pd_active = pd_strap_sync || powerdown_after_reset_cfg;
    wire irq_pending = reset_event_latched && irq_enable[RESET_EVENT_BIT] && pd_active;

    // fixed priority, highest-numbered bit first
    // one source only, so two clocks never meet on the pin mux
    function automatic prc_gp_source_type gp_pick(input logic [CLK_CFG_WIDTH-1:0] cfg);
        if (cfg[BIT_RECOVERED_FAST]) begin
            gp_pick = GP_RECOVERED_FAST;
        end else if (cfg[BIT_FREE_FAST]) begin
            gp_pick = GP_FREE_FAST;
        end else if (cfg[BIT_RECOVERED_HEARTBEAT]) begin
            gp_pick = GP_RECOVERED_HEARTBEAT;
        end else if (cfg[BIT_FREE_HEARTBEAT]) begin
            gp_pick = GP_FREE_HEARTBEAT;
        end else if (cfg[BIT_CRYSTAL]) begin
            gp_pick = GP_CRYSTAL;
        end else begin
            gp_pick = GP_NONE;
        end
    endfunction

    wire prc_gp_source_type next_gp_source = gp_pick(clk_cfg);

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            irq_enable <= IRQ_ENABLE_RESET;
            reset_event_latched <= 1'b0;
            clk_cfg <= CLK_CFG_RESET[CLK_CFG_WIDTH-1:0];
            c45_addr <= ADDR_RESET;
            ext_addr <= ADDR_RESET;
        end else begin
            irq_enable <= next_irq_enable;
            reset_event_latched <= next_latched;
            clk_cfg <= next_clk_cfg;
            c45_addr <= next_c45_addr;
            ext_addr <= next_ext_addr;
        end
    end

    // ==========================================================
    // outputs, all registered
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            int_n <= 1'b1;
            gp_clock_source <= GP_NONE;
            ref_clock_out_enable <= 1'b0;
            ref_clock_divide <= 1'b0;
        end else begin
            int_n <= !irq_pending;
            gp_clock_source <= next_gp_source;
            ref_clock_out_enable <= clk_cfg[BIT_REF_OUTPUT];
            // 50 MHz input halved so the pin still carries 25 MHz
            ref_clock_divide <= clk_cfg[BIT_REF_OUTPUT] && x50_strap_sync;
        end
    end

    // ==========================================================
    // checks
    a_irq_needs_enable: assert property (@(posedge mclk) disable iff (!nrst)
        !int_n |-> $past(irq_enable[RESET_EVENT_BIT]) && $past(reset_event_latched))
        else $error("interrupt low without enable and latch");
    a_strap_default: assert property (@(posedge mclk) disable iff (!nrst)
        capture && !(reg_write && hit_enable)
        |=> irq_enable[RESET_EVENT_BIT] == $past(pd_strap_sync))
        else $error("enable bit missed strap default");
    a_powerdown_gate: assert property (@(posedge mclk) disable iff (!nrst)
        !int_n |-> $past(pd_active))
        else $error("interrupt low without power-down config");
    a_status_latch: assert property (@(posedge mclk) disable iff (!nrst)
        capture |=> reset_event_latched [*2])
        else $error("reset event not latched");
    a_read_clears: assert property (@(posedge mclk) disable iff (!nrst)
        status_clear && !capture |=> !reset_event_latched ##1 int_n)
        else $error("status read did not clear and release");
    a_int_release: assert property (@(posedge mclk) disable iff (!nrst)
        !irq_pending |=> int_n)
        else $error("interrupt held without pending event");
    a_gp_priority: assert property (@(posedge mclk) disable iff (!nrst)
        clk_cfg[BIT_RECOVERED_FAST] |=> gp_clock_source == GP_RECOVERED_FAST)
        else $error("gp source priority broken");
    a_gp_crystal: assert property (@(posedge mclk) disable iff (!nrst)
        clk_cfg == CLK_CFG_WIDTH'(1) |=> gp_clock_source == GP_CRYSTAL)
        else $error("crystal source not selected");
    a_ref_divide: assert property (@(posedge mclk) disable iff (!nrst)
        ref_clock_divide |-> ref_clock_out_enable && $past(x50_strap_sync))
        else $error("divide without reference output");
    a_gp_free_fast: assert property (@(posedge mclk) disable iff (!nrst)
        !clk_cfg[BIT_RECOVERED_FAST] && clk_cfg[BIT_FREE_FAST]
        |=> gp_clock_source == GP_FREE_FAST)
        else $error("free fast clock not selected");
    a_gp_heartbeat: assert property (@(posedge mclk) disable iff (!nrst)
        clk_cfg[BIT_RECOVERED_HEARTBEAT] && !clk_cfg[BIT_RECOVERED_FAST]
        && !clk_cfg[BIT_FREE_FAST]
        |=> gp_clock_source == GP_RECOVERED_HEARTBEAT)
        else $error("recovered heartbeat not selected");
    a_ref_follows: assert property (@(posedge mclk) disable iff (!nrst)
        1'b1 |=> ref_clock_out_enable == $past(clk_cfg[BIT_REF_OUTPUT]))
        else $error("reference enable lags its config bit");
    a_enable_hold: assert property (@(posedge mclk) disable iff (!nrst)
        !capture && !(reg_write && hit_enable) |=> $stable(irq_enable))
        else $error("enable register changed without write");
    a_status_hold: assert property (@(posedge mclk) disable iff (!nrst)
        !capture && !status_clear |=> $stable(reset_event_latched))
        else $error("status latch changed without event or read");
    a_cfg_hold: assert property (@(posedge mclk) disable iff (!nrst)
        !(reg_write && hit_clk) |=> $stable(clk_cfg))
        else $error("clock config changed without write");
    a_addr_hold: assert property (@(posedge mclk) disable iff (!nrst)
        !c45_addr_load && !c45_addr_inc |=> $stable(c45_addr))
        else $error("frame address moved without load or increment");

    c_status_read: cover property (@(posedge mclk) disable iff (!nrst) status_clear);
    c_irq_asserted: cover property (@(posedge mclk) disable iff (!nrst) $fell(int_n));
    c_indirect_write: cover property (@(posedge mclk) disable iff (!nrst)
        reg_write && is_ext_data && hit_clk);
    c_read_increment: cover property (@(posedge mclk) disable iff (!nrst) c45_addr_inc);
    c_gp_mixed: cover property (@(posedge mclk) disable iff (!nrst)
        clk_cfg[BIT_RECOVERED_FAST] && clk_cfg[BIT_CRYSTAL]);

endmodule

`default_nettype wire

// ---- prc_mdio_master.sv ----
// Purpose: station management master model for the reset-event and clock-output bank
// Assumes: data line pulled up; mdc half period of 4 mclk, above the 3 mclk minimum
// Notes: mdc stands low between frames; master releases the line for read turnaround
`timescale 1ns/1ps
`default_nettype none

module prc_mdio_master
    import prc_pkg::*;
(
    input wire logic mclk,
    output logic mdc,
    output logic mdio_line,
    input wire logic mdio_out,
    input wire logic mdio_oe
);
    logic drive_en;
    logic drive_bit;

    // ==========================================================
    // open-drain wire: pull-up wins wherever nobody drives low
    assign mdio_line = (mdio_oe ? mdio_out : 1'b1) & (drive_en ? drive_bit : 1'b1);

    initial begin
        mdc = 1'b0;
        drive_en = 1'b0;
        drive_bit = 1'b1;
    end

    // ==========================================================
    // one bit: data set with mdc low, sampled just before the rise
    task automatic bit_cycle(input logic en, input logic b, output logic seen);
        mdc = 1'b0;
        drive_en = en;
        drive_bit = b;
        repeat (4) @(negedge mclk);
        seen = mdio_line;
        mdc = 1'b1;
        repeat (4) @(negedge mclk);
    endtask

    task automatic xfer(input logic [1:0] st, input logic [1:0] op, input logic [4:0] pa,
            input logic [4:0] ra, input logic [15:0] wd, output logic [15:0] rd);
        logic [31:0] word;
        logic rel;
        logic s;
        word = {st, op, pa, ra, 2'b10, wd};
        rel = (st == ST_C22) ? (op == OP_C22_READ) : op[1];
        rd = 16'h0000;
        @(negedge mclk);
        for (int i = 0; i < 32; i++) bit_cycle(1'b1, 1'b1, s);
        for (int i = 31; i >= 0; i--) begin
            bit_cycle(!(rel && i < 18), word[i], s);
            if (i < 16) rd[i] = s;
        end
        // released idle bit follows the data; the device already dropped its drive at the last data rise
        bit_cycle(1'b0, 1'b1, s);
        mdc = 1'b0;
    endtask
endmodule
`default_nettype wire

// ---- test_phy_reset_irq_and_clock_out_cfg.sv ----
// Purpose: self-checking bench for the reset-event interrupt and clock-output bank
// Assumes: straps settle before reset release; inputs change at the falling edge
// Notes: registers reached only through management frames from the master model
`timescale 1ns/1ps
`default_nettype none

`define CHK(name, exp, got) \
    begin \
        checks_done++; \
        if ((got) !== (exp)) begin \
            failures++; \
            $display("[FAIL] %s expected %0h seen %0h", name, exp, got); \
        end \
    end

module test_phy_reset_irq_and_clock_out_cfg
    import prc_pkg::*;
;
    localparam logic [4:0] PA = 5'h03;
    logic mclk;
    logic nrst;
    logic mdc;
    logic mdio_line;
    logic mdio_out;
    logic mdio_oe;
    logic pd_strap;
    logic x50_strap;
    logic pd_cfg;
    logic int_n;
    prc_gp_source_type gp_src;
    logic ref_en;
    logic ref_div;
    int failures = 0;
    int checks_done = 0;
    int cycles = 0;
    logic [15:0] cfg_tab [9] = '{16'h0020, 16'h0010, 16'h0004, 16'h0002, 16'h0001,
        16'h003f, 16'h0017, 16'h0003, 16'h0008};
    prc_gp_source_type src_tab [9] = '{GP_RECOVERED_FAST,
        GP_FREE_FAST,
        GP_RECOVERED_HEARTBEAT,
        GP_FREE_HEARTBEAT,
        GP_CRYSTAL,
        GP_RECOVERED_FAST, GP_FREE_FAST, GP_FREE_HEARTBEAT,
        GP_NONE};

    prc_reg_bank #(.PHY_ADDR(PA)) i_prc_reg_bank (.mclk(mclk), .nrst(nrst), .mdc(mdc),
        .mdio_in(mdio_line), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
        .powerdown_strap(pd_strap), .crystal_50mhz_strap(x50_strap),
        .powerdown_after_reset_cfg(pd_cfg), .int_n(int_n), .gp_clock_source(gp_src),
        .ref_clock_out_enable(ref_en), .ref_clock_divide(ref_div));

    prc_mdio_master i_prc_mdio_master (.mclk(mclk), .mdc(mdc), .mdio_line(mdio_line),
        .mdio_out(mdio_out), .mdio_oe(mdio_oe));

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    // ==========================================================
    // access tasks
    task automatic reg_wr(input logic [15:0] a, input logic [15:0] d);
        logic [15:0] nul;
        i_prc_mdio_master.xfer(ST_C45, OP_C45_ADDR, PA, SUBSYS_DEVAD, a, nul);
        i_prc_mdio_master.xfer(ST_C45, OP_C45_WRITE, PA, SUBSYS_DEVAD, d, nul);
    endtask

    task automatic reg_rd(input logic [15:0] a, output logic [15:0] d);
        logic [15:0] nul;
        i_prc_mdio_master.xfer(ST_C45, OP_C45_ADDR, PA, SUBSYS_DEVAD, a, nul);
        i_prc_mdio_master.xfer(ST_C45, OP_C45_READ_INC, PA, SUBSYS_DEVAD, 16'h0000, d);
    endtask

    task automatic do_reset(input logic pd, input logic x50, input logic cfg);
        nrst = 1'b0;
        pd_strap = pd;
        x50_strap = x50;
        pd_cfg = cfg;
        repeat (2) @(negedge mclk);
        nrst = 1'b1;
        repeat (8) @(negedge mclk);
    endtask

    task automatic results();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // hang guard: whole sequence needs roughly 26k cycles
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 90000) begin
            failures++;
            results();
        end
    end

    // ==========================================================
    // tests
    initial begin
        logic [15:0] rd;
        nrst = 1'b0;
        pd_strap = 1'b0;
        x50_strap = 1'b0;
        pd_cfg = 1'b0;
        do_reset(1'b0, 1'b0, 1'b0);
        `CHK("int_n", 1'b1, int_n);
        `CHK("ref_en", 1'b1, ref_en);
        `CHK("ref_div", 1'b0, ref_div);
        reg_rd(ADDR_IRQ_ENABLE, rd);
        `CHK("enable", 16'h000e, rd);
        reg_rd(ADDR_CLK_CFG, rd);
        `CHK("clk_cfg", 16'h0008, rd);
        reg_wr(ADDR_IRQ_ENABLE, 16'h001e);
        `CHK("int_n", 1'b1, int_n);
        reg_rd(ADDR_IRQ_STATUS, rd);
        `CHK("status", 16'h0010, rd);
        reg_rd(ADDR_IRQ_STATUS, rd);
        `CHK("status", 16'h0000, rd);
        $display("test reset_defaults done");

        do_reset(1'b1, 1'b1, 1'b0);
        `CHK("int_n", 1'b0, int_n);
        `CHK("ref_div", 1'b1, ref_div);
        reg_rd(ADDR_IRQ_ENABLE, rd);
        `CHK("enable", 16'h001e, rd);
        `CHK("int_n", 1'b0, int_n);
        reg_rd(ADDR_IRQ_STATUS, rd);
        `CHK("status", 16'h0010, rd);
        `CHK("int_n", 1'b1, int_n);
        reg_wr(ADDR_CLK_CFG, 16'h0000);
        `CHK("ref_div", 1'b0, ref_div);
        $display("test strap_powerdown done");

        do_reset(1'b0, 1'b0, 1'b1);
        `CHK("int_n", 1'b1, int_n);
        reg_wr(ADDR_IRQ_ENABLE, 16'h001e);
        `CHK("int_n", 1'b0, int_n);
        reg_wr(ADDR_IRQ_ENABLE, 16'h000e);
        `CHK("int_n", 1'b1, int_n);
        $display("test cfg_powerdown done");

        for (int i = 0; i < 9; i++) begin
            reg_wr(ADDR_CLK_CFG, cfg_tab[i]);
            `CHK("gp_src", src_tab[i], gp_src);
            `CHK("ref_en", cfg_tab[i][3], ref_en);
        end
        reg_wr(ADDR_CLK_CFG, 16'hffff);
        reg_rd(ADDR_CLK_CFG, rd);
        `CHK("clk_cfg", 16'h003f, rd);
        $display("test clock_select done");

        i_prc_mdio_master.xfer(ST_C22, OP_C22_WRITE, PA, C22_EXT_ADDR_REG, ADDR_CLK_CFG, rd);
        i_prc_mdio_master.xfer(ST_C22, OP_C22_WRITE, PA, C22_EXT_DATA_REG, 16'h0004, rd);
        `CHK("gp_src", GP_RECOVERED_HEARTBEAT, gp_src);
        i_prc_mdio_master.xfer(ST_C22, OP_C22_READ, PA, C22_EXT_DATA_REG, 16'h0000, rd);
        `CHK("c22_data", 16'h0004, rd);
        $display("test indirect done");

        reg_rd(16'hff20, rd);
        `CHK("unmapped", 16'h0000, rd);
        i_prc_mdio_master.xfer(ST_C22, OP_C22_READ, 5'h04, C22_EXT_DATA_REG, 16'h0000, rd);
        `CHK("other_phy", 16'hffff, rd);
        i_prc_mdio_master.xfer(ST_C45, OP_C45_ADDR, PA, 5'h1d, ADDR_CLK_CFG, rd);
        i_prc_mdio_master.xfer(ST_C45, OP_C45_WRITE, PA, 5'h1d, 16'h0020, rd);
        `CHK("gp_src", GP_RECOVERED_HEARTBEAT, gp_src);
        $display("test refusals done");
        results();
    end
endmodule
`default_nettype wire
